/* hdl/gpio_port_pkg.sv */
// Purpose: shared constants and types for the steered 8-bit general-purpose port
// Assumes: 8-bit register data, 3-bit register index
// Notes: sync vector holds port A bits 7..0, then port_c_bit1 and port_b_bit3
`default_nettype none
package gpio_port_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int PORT_W = 8;
    localparam int ADDR_W = 3;
    localparam int SYNC_W = 10;
    localparam int IDX_PC1 = 8;
    localparam int IDX_PB3 = 9;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFS_PIN = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_DIR = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_LAT = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_ANA = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_ALT = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_SET = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_CLR = 3'h6;

    // ****************************************
    // reset values, masks and field positions
    // ****************************************
    localparam logic [PORT_W-1:0] RST_DIR = 8'hff;
    localparam logic [PORT_W-1:0] RST_LAT = 8'h00;
    localparam logic [PORT_W-1:0] RST_ANA = 8'h2f;
    localparam logic [PORT_W-1:0] ANA_MASK = 8'h2f;
    localparam logic [1:0] RST_ALT = 2'h0;
    localparam int ALT_SS_BIT = 1;
    localparam int ALT_CAP2_BIT = 0;
    localparam logic [2:0] SS_PIN_DEF = 3'h5;
    localparam logic [2:0] SS_PIN_ALT = 3'h0;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic en;
        logic oe;
        logic drv;
    } drive_t;

    typedef struct packed {
        logic [PORT_W-1:0] dir;
        logic [PORT_W-1:0] lat;
        logic [PORT_W-1:0] ana;
        logic [1:0] alt;
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] filt;
        logic [PORT_W-1:0] rdata;
        logic [PORT_W-1:0] pin_out;
        logic [PORT_W-1:0] pin_oe;
        drive_t pc1_ovr;
        drive_t pb3_ovr;
        logic ss_level;
        logic cap2_level;
    } state_t;

endpackage

`default_nettype wire

/* hdl/gpio_port_with_pin_steering.sv */
// Purpose: 8-bit bidirectional port with direction, latch, analog select and pin steering
// Assumes: single core_clk at 100 MHz, synchronous active-low reset_n
// Notes: pad outputs and enables are registered, so they follow register changes one edge later
//
// Operation
// - eight pins, each independently an input or an output
// - direction bit one turns the pin driver off
// - direction bit zero drives the pin from its latch bit
// - pin register reads pin levels; writing it loads the latch
// - bit set and clear writes read pins, merge the change, store into the latch
// - latch write equals pin write; latch read returns held latch
// - analog-selected pins read zero on every digital read
// - analog select never changes what the pin drives
// - direction bits steer drivers even for analog pins
// - an enabled peripheral takes the pin away from the port
// - steering bit 1 puts slave select on bit5 or bit0
// - steering bit 0 puts capture unit two on c1 or b3
// - steering keeps directions, routes overrides, leaves unselected pin alone
// - steering bits 7..2 read zero
// - highest priority enabled peripheral owns a shared pin
// - every direction bit is one after reset
// - analog select only on bits 5,3..0, resets set, kills digital input
`timescale 1ns/1ns
`default_nettype none

module gpio_port_with_pin_steering
    import gpio_port_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [PORT_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [PORT_W-1:0] reg_rdata,
    input wire logic [PORT_W-1:0] pa_in,
    output logic [PORT_W-1:0] pa_out,
    output logic [PORT_W-1:0] pa_oe,
    output logic [PORT_W-1:0] pa_analog_en,
    input wire drive_t [PORT_W-1:0] periph_hi,
    input wire drive_t [PORT_W-1:0] periph_lo,
    input wire logic ss_en,
    output logic ss_level,
    input wire logic pc1_in,
    input wire logic pb3_in,
    input wire drive_t cap2_drive,
    output drive_t pc1_ovr,
    output drive_t pb3_ovr,
    output logic cap2_level
);

    // ****************************************
    // state
    // ****************************************
    state_t s_q;
    state_t s_d;
    logic [PORT_W-1:0] pin_rd;
    logic [PORT_W-1:0] rd_val;
    logic [2:0] ss_idx;
    logic [PORT_W-1:0] drv_oe;
    logic [PORT_W-1:0] drv_out;

    // ****************************************
    // per-pin driver priority
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_pin
            always_comb begin
                if (periph_hi[gi].en) begin
                    // highest priority peripheral owns the pin
                    drv_oe[gi] = periph_hi[gi].oe;
                    drv_out[gi] = periph_hi[gi].drv;
                end else if (periph_lo[gi].en) begin
                    drv_oe[gi] = periph_lo[gi].oe;
                    drv_out[gi] = periph_lo[gi].drv;
                end else if (ss_en && (ss_idx == 3'(gi))) begin
                    // slave select is an input; it forces the driver off
                    drv_oe[gi] = 1'b0;
                    drv_out[gi] = 1'b0;
                end else begin
                    // analog select plays no part here
                    drv_oe[gi] = ~s_q.dir[gi];
                    drv_out[gi] = s_q.lat[gi];
                end
            end
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        // three-stage pin synchroniser
        s_d.s1 = {pb3_in, pc1_in, pa_in};
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        for (int i = 0; i < SYNC_W; i++) begin
            if (s_q.s2[i] == s_q.s3[i]) begin
                s_d.filt[i] = s_q.s3[i];
            end
        end

        // analog pins read zero, digital buffer off
        pin_rd = s_q.filt[PORT_W-1:0] & ~s_q.ana;

        // read decode
        rd_val = '0;
        if (reg_addr == OFS_PIN) begin
            rd_val = pin_rd;
        end else if (reg_addr == OFS_DIR) begin
            rd_val = s_q.dir;
        end else if (reg_addr == OFS_LAT) begin
            rd_val = s_q.lat;
        end else if (reg_addr == OFS_ANA) begin
            rd_val = s_q.ana;
        end else if (reg_addr == OFS_ALT) begin
            rd_val = {6'h00, s_q.alt};
        end
        s_d.rdata = reg_rd ? rd_val : '0;

        // write decode
        if (reg_wr) begin
            if (reg_addr == OFS_PIN) begin
                s_d.lat = reg_wdata;
            end else if (reg_addr == OFS_LAT) begin
                s_d.lat = reg_wdata;
            end else if (reg_addr == OFS_DIR) begin
                s_d.dir = reg_wdata;
            end else if (reg_addr == OFS_ANA) begin
                s_d.ana = reg_wdata & ANA_MASK;
            end else if (reg_addr == OFS_ALT) begin
                s_d.alt = reg_wdata[1:0];
            end else if (reg_addr == OFS_SET) begin
                // bit set merges into the pin levels, not the latch
                s_d.lat = pin_rd | reg_wdata;
            end else if (reg_addr == OFS_CLR) begin
                s_d.lat = pin_rd & ~reg_wdata;
            end
        end

        // pad drivers
        s_d.pin_oe = drv_oe;
        s_d.pin_out = drv_out;

        // slave select steering
        ss_idx = s_q.alt[ALT_SS_BIT] ? SS_PIN_ALT : SS_PIN_DEF;
        s_d.ss_level = pin_rd[ss_idx];

        // capture unit two steering; the unselected pin sees no override
        if (s_q.alt[ALT_CAP2_BIT]) begin
            s_d.pc1_ovr = '0;
            s_d.pb3_ovr = cap2_drive;
            s_d.cap2_level = s_q.filt[IDX_PB3];
        end else begin
            s_d.pc1_ovr = cap2_drive;
            s_d.pb3_ovr = '0;
            s_d.cap2_level = s_q.filt[IDX_PC1];
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.dir <= RST_DIR;
            s_q.lat <= RST_LAT;
            s_q.ana <= RST_ANA;
            s_q.alt <= RST_ALT;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign pa_out = s_q.pin_out;
    assign pa_oe = s_q.pin_oe;
    assign pa_analog_en = s_q.ana;
    assign ss_level = s_q.ss_level;
    assign pc1_ovr = s_q.pc1_ovr;
    assign pb3_ovr = s_q.pb3_ovr;
    assign cap2_level = s_q.cap2_level;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_rd_pin;
        reg_rd && reg_addr == OFS_PIN |=> reg_rdata == $past(pin_rd);
    endproperty
    a_rd_pin: assert property (p_rd_pin) else $error("pin read wrong");

    property p_rd_lat;
        reg_rd && reg_addr == OFS_LAT |=> reg_rdata == $past(s_q.lat) ##1 (reg_rdata == 8'h00 || $past(reg_rd));
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("latch read wrong");

    property p_wr_pin;
        reg_wr && reg_addr == OFS_PIN |=> s_q.lat == $past(reg_wdata);
    endproperty
    a_wr_pin: assert property (p_wr_pin) else $error("pin write missed latch");

    property p_set;
        reg_wr && reg_addr == OFS_SET |=> s_q.lat == ($past(pin_rd) | $past(reg_wdata));
    endproperty
    a_set: assert property (p_set) else $error("bit set merge wrong");

    property p_ana_zero;
        reg_rd && reg_addr == OFS_PIN && s_q.ana[0] |=> !reg_rdata[0];
    endproperty
    a_ana_zero: assert property (p_ana_zero) else $error("analog pin read one");

    property p_rd_dir;
        reg_rd && reg_addr == OFS_DIR |=> reg_rdata == $past(s_q.dir);
    endproperty
    a_rd_dir: assert property (p_rd_dir) else $error("direction read wrong");

    property p_rd_ana;
        reg_rd && reg_addr == OFS_ANA |=> reg_rdata == ($past(s_q.ana) & ANA_MASK);
    endproperty
    a_rd_ana: assert property (p_rd_ana) else $error("analog select read wrong");

    property p_ana_wr;
        reg_wr && reg_addr == OFS_ANA |=> s_q.ana == ($past(reg_wdata) & ANA_MASK);
    endproperty
    a_ana_wr: assert property (p_ana_wr) else $error("analog select write wrong");

    property p_clr;
        reg_wr && reg_addr == OFS_CLR |=> s_q.lat == ($past(pin_rd) & ~$past(reg_wdata));
    endproperty
    a_clr: assert property (p_clr) else $error("bit clear merge wrong");

    property p_wr_lat;
        reg_wr && reg_addr == OFS_LAT |=> s_q.lat == $past(reg_wdata);
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("latch write missed");

    property p_idle_rd;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_idle_rd: assert property (p_idle_rd) else $error("read data left standing");

    // ****************************************
    // pad driver checks
    // ****************************************

    property p_input;
        s_q.dir[1] && !periph_hi[1].en && !periph_lo[1].en |=> !pa_oe[1];
    endproperty
    a_input: assert property (p_input) else $error("input pin driven");

    property p_drive;
        !s_q.dir[2] && !periph_hi[2].en && !periph_lo[2].en
            |=> pa_oe[2] && pa_out[2] == $past(s_q.lat[2]);
    endproperty
    a_drive: assert property (p_drive) else $error("output pin not driven");

    property p_ana_drive;
        s_q.ana[3] && !s_q.dir[3] && !periph_hi[3].en && !periph_lo[3].en
            |=> pa_oe[3] && pa_out[3] == $past(s_q.lat[3]);
    endproperty
    a_ana_drive: assert property (p_ana_drive) else $error("analog pin lost its driver");

    property p_lo_win;
        !periph_hi[7].en && periph_lo[7].en
            |=> pa_oe[7] == $past(periph_lo[7].oe) && pa_out[7] == $past(periph_lo[7].drv);
    endproperty
    a_lo_win: assert property (p_lo_win) else $error("peripheral did not take pin");

    // ****************************************
    // steering checks
    // ****************************************

    property p_alt_rd;
        reg_rd && reg_addr == OFS_ALT |=> reg_rdata[7:2] == 6'h00;
    endproperty
    a_alt_rd: assert property (p_alt_rd) else $error("steering high bits set");

    property p_ss;
        s_q.alt[ALT_SS_BIT] |=> ss_level == $past(pin_rd[0]);
    endproperty
    a_ss: assert property (p_ss) else $error("slave select not on bit0");

    property p_cap2;
        s_q.alt[ALT_CAP2_BIT] |=> !pc1_ovr.en && pb3_ovr == $past(cap2_drive);
    endproperty
    a_cap2: assert property (p_cap2) else $error("capture two misrouted");

    property p_ss_def;
        !s_q.alt[ALT_SS_BIT] |=> ss_level == $past(pin_rd[SS_PIN_DEF]);
    endproperty
    a_ss_def: assert property (p_ss_def) else $error("slave select not on bit5");

    property p_cap2_def;
        !s_q.alt[ALT_CAP2_BIT] |=> pb3_ovr == 3'h0 && pc1_ovr == $past(cap2_drive);
    endproperty
    a_cap2_def: assert property (p_cap2_def) else $error("capture two not on c1");

    property p_ss_drv;
        ss_en && !s_q.alt[ALT_SS_BIT] && !periph_hi[5].en && !periph_lo[5].en
            |=> !pa_oe[5];
    endproperty
    a_ss_drv: assert property (p_ss_drv) else $error("slave select pin driven");

    property p_cap2_lvl;
        s_q.alt[ALT_CAP2_BIT] |=> cap2_level == $past(s_q.filt[IDX_PB3]);
    endproperty
    a_cap2_lvl: assert property (p_cap2_lvl) else $error("capture two level misrouted");

    // ****************************************
    // priority, synchroniser and reset checks
    // ****************************************

    property p_prio;
        periph_hi[7].en && periph_lo[7].en
            |=> pa_oe[7] == $past(periph_hi[7].oe) && pa_out[7] == $past(periph_hi[7].drv);
    endproperty
    a_prio: assert property (p_prio) else $error("low priority won pin");

    property p_sync_hold;
        s_q.s2[0] != s_q.s3[0] |=> s_q.filt[0] == $past(s_q.filt[0]);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("filter took unsettled bit");

    property p_sync_take;
        s_q.s2[0] == s_q.s3[0] |=> s_q.filt[0] == $past(s_q.s3[0]);
    endproperty
    a_sync_take: assert property (p_sync_take) else $error("filter missed settled level");

    property p_rst;
        @(posedge core_clk) disable iff (1'b0)
        !reset_n |=> s_q.dir == RST_DIR && s_q.ana == RST_ANA;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");

    property p_rst_out;
        @(posedge core_clk) disable iff (1'b0)
        !reset_n |=> pa_oe == 8'h00 && reg_rdata == 8'h00 && pa_analog_en == RST_ANA;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");

endmodule // gpio_port_with_pin_steering

`default_nettype wire

/* testbench/gpio_pin_world.sv */
// Purpose: pads and outside world around the port
// Assumes: port pads not driven by the port follow the bench's external drive where ext_en is set
// Notes: undriven and unselected pads toggle every cycle so no stale level is read
`timescale 1ns/1ns
`default_nettype none
module gpio_pin_world
    import gpio_port_pkg::*;
(
    input wire logic core_clk,
    input wire logic [PORT_W-1:0] pa_out,
    input wire logic [PORT_W-1:0] pa_oe,
    input wire logic [PORT_W-1:0] ext_val,
    input wire logic [PORT_W-1:0] ext_en,
    input wire drive_t pc1_ovr,
    input wire drive_t pb3_ovr,
    output logic [PORT_W-1:0] pa_in,
    output logic pc1_in,
    output logic pb3_in
);
    logic tog = 1'b0;
    always @(posedge core_clk) tog <= ~tog;
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            pa_in[i] = pa_oe[i] ? pa_out[i] : (ext_en[i] ? ext_val[i] : tog);
        end
        pc1_in = pc1_ovr.oe ? pc1_ovr.drv : tog;
        pb3_in = pb3_ovr.oe ? pb3_ovr.drv : tog;
    end
endmodule // gpio_pin_world
`default_nettype wire

/* testbench/gpio_port_with_pin_steering_tb_top.sv */
// Purpose: register-level tests of the steered port
// Assumes: design asserts sit inside the design files
// Notes: pin reads wait six edges for the input synchroniser
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module gpio_port_with_pin_steering_tb_top;
    import gpio_port_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [PORT_W-1:0] reg_wdata = '0, ext_val = '0, ext_en = '0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, ss_en = 1'b0, pc1_in, pb3_in, ss_level, cap2_level;
    logic [PORT_W-1:0] reg_rdata, pa_in, pa_out, pa_oe, pa_analog_en;
    drive_t [PORT_W-1:0] periph_hi = '0, periph_lo = '0;
    drive_t cap2_drive = '0, pc1_ovr, pb3_ovr;
    int error_cnt = 0, num_checks = 0, cycles = 0;
    always #5 core_clk = ~core_clk;
    gpio_port_with_pin_steering uut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pa_in(pa_in),
        .pa_out(pa_out), .pa_oe(pa_oe), .pa_analog_en(pa_analog_en), .periph_hi(periph_hi),
        .periph_lo(periph_lo), .ss_en(ss_en), .ss_level(ss_level), .pc1_in(pc1_in), .pb3_in(pb3_in),
        .cap2_drive(cap2_drive), .pc1_ovr(pc1_ovr), .pb3_ovr(pb3_ovr), .cap2_level(cap2_level));
    gpio_pin_world world (.core_clk(core_clk), .pa_out(pa_out), .pa_oe(pa_oe), .ext_val(ext_val),
        .ext_en(ext_en), .pc1_ovr(pc1_ovr), .pb3_ovr(pb3_ovr), .pa_in(pa_in), .pc1_in(pc1_in),
        .pb3_in(pb3_in));
    // ****************************************
    // bus tasks
    // ****************************************
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [PORT_W-1:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [PORT_W-1:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("rdata", e, reg_rdata)
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(OFS_DIR, 8'hff);
        rd(OFS_ANA, 8'h2f);
        rd(OFS_ALT, 8'h00);
        rd(OFS_LAT, 8'h00);
        rd(3'h7, 8'h00);
        `CHK("oe_rst", 8'h00, pa_oe)
        `CHK("ana_pin", 8'h2f, pa_analog_en)
        ext_en <= 8'hff;
        ext_val <= 8'h3c;
        wr(OFS_ANA, 8'h00);
        settle(6);
        `CHK("ana_pin0", 8'h00, pa_analog_en)
        rd(OFS_PIN, 8'h3c);
        wr(OFS_ANA, 8'hff);
        rd(OFS_ANA, 8'h2f);
        settle(6);
        rd(OFS_PIN, 8'h10);
        wr(OFS_DIR, 8'h00);
        wr(OFS_PIN, 8'ha5);
        settle(1);
        `CHK("oe", 8'hff, pa_oe)
        `CHK("out", 8'ha5, pa_out)
        rd(OFS_LAT, 8'ha5);
        settle(6);
        rd(OFS_PIN, 8'h80);
        wr(OFS_SET, 8'h02);
        rd(OFS_LAT, 8'h82);
        settle(6);
        wr(OFS_CLR, 8'h80);
        rd(OFS_LAT, 8'h00);
        wr(OFS_LAT, 8'h80);
        rd(OFS_LAT, 8'h80);
        @(posedge core_clk);
        periph_hi[7] <= '{en: 1'b1, oe: 1'b1, drv: 1'b0};
        periph_lo[7] <= '{en: 1'b1, oe: 1'b1, drv: 1'b1};
        settle(3);
        `CHK("hi", 8'h00, pa_out)
        @(posedge core_clk);
        periph_hi[7] <= '0;
        settle(3);
        `CHK("lo", 8'h80, pa_out)
        @(posedge core_clk);
        periph_lo[7] <= '{en: 1'b1, oe: 1'b0, drv: 1'b0};
        settle(3);
        `CHK("own", 8'h7f, pa_oe)
        @(posedge core_clk);
        periph_lo[7] <= '0;
        wr(OFS_ANA, 8'h00);
        ss_en <= 1'b1;
        wr(OFS_ALT, 8'hff);
        rd(OFS_ALT, 8'h03);
        settle(1);
        `CHK("ss_alt", 8'hfe, pa_oe)
        rd(OFS_DIR, 8'h00);
        wr(OFS_ALT, 8'h00);
        settle(1);
        `CHK("ss_def", 8'hdf, pa_oe)
        settle(6);
        `CHK("ss_lvl", 1'b1, ss_level)
        @(posedge core_clk);
        cap2_drive <= '{en: 1'b1, oe: 1'b1, drv: 1'b1};
        wr(OFS_ALT, 8'h01);
        settle(1);
        `CHK("b3", 3'h7, pb3_ovr)
        `CHK("c1", 3'h0, pc1_ovr)
        settle(6);
        `CHK("cap2", 1'b1, cap2_level)
        wr(OFS_ALT, 8'h00);
        settle(1);
        `CHK("c1b", 3'h7, pc1_ovr)
        `CHK("b3b", 3'h0, pb3_ovr)
        // second reset in mid-run: every pin must fall back to input
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(OFS_DIR, 8'hff);
        rd(OFS_ANA, 8'h2f);
        `CHK("oe_rst2", 8'h00, pa_oe)
        end_of_test();
    end
endmodule // gpio_port_with_pin_steering_tb_top
`default_nettype wire
